// >>> rxo_pins.sv
`timescale 1ns/1ps
`include "rxo_regs.svh"
// Operation
// - decimated clock is clk divided by the programmed integer divisor; values below 2 divide by 2.
// - sample clock output rate set by its own programmable divisor.
// - active-high reset input asynchronously clears the stream path, dividers and gain modulators, not the serializer.
// - that reset leaves configuration registers untouched.
// - sense input level readable as a status bit.
// - control bit 3 shows sync of the selected module.
// - control bit 3 may instead follow its own register bit.
// - control bits 2..0 follow their register bits as outputs.
// - tuner mode puts pump gain bit1 on bit 2, bit2 on bit 0.
// - serializer mode maps enable, clock, data to bits 2, 1, 0.
// - both gain outputs are positive sigma-delta bitstreams.
// - gain output 1 alone serves single-stage gain control.
// - parallel mode pulses byte strobe once per valid byte.
// - format bit 1 gives parallel bytes, 0 gives serial on bit 0.
// - serial bytes go out most significant bit first.
// - serial mode presents one bit per bit clock.
// - output enable gates stream pins; decoding continues anyway.
// - valid flag high only for corrected data, low for check and gap.
// - writing one to pipeline reset drops the valid flag.
// - error flag asserted from start of errored frame, released after.
// - frame start flag marks first bit or first byte of a frame.
module rxo_pins #(
    parameter int GAIN_W   = 8,
    parameter int DIV_W    = 8,
    parameter int SCL_HALF = `RXO_SCL_HALF
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 dpReset,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // Decoded stream from the decoder
    input  wire logic                 inValid,
    input  wire logic [7:0]           inByte,
    input  wire logic                 inIsData,
    input  wire logic                 inFrameStart,
    input  wire logic                 inFrameErr,
    output logic                      inReady,
    // Status inputs
    input  wire logic [2:0]           syncFlags,
    input  wire logic                 senseIn,
    input  wire logic                 outputEnable_n,
    // Stream pins
    output logic [7:0]                channelOut,
    output logic                      validOut,
    output logic                      byteStrobe,
    output logic                      frameStart,
    output logic                      frameError_n,
    output logic                      streamOe_n,
    // Control, gain and clock pins
    output logic [3:0]                ctrlOut,
    output logic [1:0]                gainOut,
    output logic                      decimClkOut,
    output logic                      sampleClkOut
);
    import rxo_pkg::*;

    generate
        if (GAIN_W < 2 || GAIN_W > 8 || DIV_W < 2 || DIV_W > 8 || SCL_HALF < 1) begin : gChk
            $error("rxo_pins: unsupported parameter value");
        end
    endgenerate

    // Configuration registers, cleared only by nrst
    logic [31:0]     cfg;
    logic [31:0]     ctl;
    logic [31:0]     divs;
    logic [31:0]     gains;
    logic [7:0]      serData;
    logic            serGo;
    logic            fecRst;
    logic            wrEn;
    logic            fmtPar;
    rxo_low_mode_t   lowMode;
    rxo_sync_src_t   syncSrc;

    assign wrEn    = psel && penable && pready && pwrite;
    assign fmtPar  = cfg[`RXO_CFG_FMT_BIT];
    assign lowMode = rxo_low_mode_t'(cfg[`RXO_CFG_MODE_LO +: 2]);
    assign syncSrc = rxo_sync_src_t'(cfg[`RXO_CFG_SRC_LO +: 2]);

    // Serializer state
    rxo_ser_state_t  serState;
    logic [7:0]      serShift;
    logic [2:0]      serBit;
    logic [15:0]     serPhase;
    logic            serScl;
    logic            serEn;

    // Stream state
    logic [7:0]      shiftReg;
    logic [2:0]      bitCnt;
    logic            busy;
    logic            accept;
    logic            next_busy;
    logic            senseReg;

    assign accept    = inValid && inReady;
    assign next_busy = !fmtPar && (accept || (busy && bitCnt != 3'd7));

    // APB answer one cycle into the access phase
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && penable && !pready) begin
                case (paddr)
                    `RXO_CFG_OFF:    prdata <= cfg;
                    `RXO_CTL_OFF:    prdata <= ctl;
                    `RXO_SER_OFF:    prdata <= {24'h00_0000, serData};
                    `RXO_DIV_OFF:    prdata <= divs;
                    `RXO_GAIN_OFF:   prdata <= gains;
                    `RXO_FECRST_OFF: prdata <= 32'h0000_0000;
                    `RXO_STAT_OFF: begin
                        prdata[`RXO_ST_SENSE]        <= senseReg;
                        prdata[`RXO_ST_SERBUSY]      <= serState != RXO_SER_IDLE;
                        prdata[`RXO_ST_SYNC_LO +: 3] <= syncFlags;
                        prdata[`RXO_ST_VALID]        <= validOut;
                        prdata[`RXO_ST_ERR]          <= !frameError_n;
                    end
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Register writes; dpReset deliberately absent here
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg     <= `RXO_CFG_RST;
            ctl     <= `RXO_CTL_RST;
            divs    <= `RXO_DIV_RST;
            gains   <= `RXO_GAIN_RST;
            serData <= 8'h00;
            serGo   <= 1'b0;
            fecRst  <= 1'b0;
        end else begin
            serGo  <= 1'b0;
            fecRst <= 1'b0;
            if (wrEn) begin
                case (paddr)
                    `RXO_CFG_OFF:  cfg   <= {26'h000_0000, pwdata[5:0]};
                    `RXO_CTL_OFF:  ctl   <= {26'h000_0000, pwdata[5:0]};
                    `RXO_DIV_OFF:  divs  <= {16'h0000, pwdata[15:0]};
                    `RXO_GAIN_OFF: gains <= {16'h0000, pwdata[15:0]};
                    `RXO_SER_OFF: begin
                        serData <= pwdata[7:0];
                        serGo   <= 1'b1;
                    end
                    `RXO_FECRST_OFF: fecRst <= pwdata[0];
                    default: ;
                endcase
            end
        end
    end

    // Sense pin sampled; inputs are synchronous to clk
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            senseReg <= 1'b0;
        end else begin
            senseReg <= senseIn;
        end
    end

    // Output stream path; cleared by either reset, pipeline reset clears all but channelOut and shiftReg
    always_ff @(posedge clk or negedge nrst or posedge dpReset) begin
        if (!nrst || dpReset) begin
            channelOut   <= 8'h00;
            validOut     <= 1'b0;
            byteStrobe   <= 1'b0;
            frameStart   <= 1'b0;
            frameError_n <= 1'b1;
            shiftReg     <= 8'h00;
            bitCnt       <= 3'd0;
            busy         <= 1'b0;
            inReady      <= 1'b0;
        end else if (fecRst) begin
            validOut     <= 1'b0;
            byteStrobe   <= 1'b0;
            frameStart   <= 1'b0;
            frameError_n <= 1'b1;
            busy         <= 1'b0;
            bitCnt       <= 3'd0;
            inReady      <= 1'b0;
        end else begin
            busy       <= next_busy;
            inReady    <= fmtPar || !next_busy;
            byteStrobe <= 1'b0;
            frameStart <= 1'b0;
            if (accept) begin
                if (inFrameStart) begin
                    frameError_n <= !inFrameErr;
                end
                frameStart <= inFrameStart && inIsData;
                validOut   <= inIsData;
                if (fmtPar) begin
                    channelOut <= inByte;
                    byteStrobe <= inIsData;
                end else begin
                    // Serial: first bit is the MSB, rest shifted out
                    channelOut <= {7'h00, inByte[7]};
                    shiftReg   <= inByte;
                    bitCnt     <= 3'd1;
                end
            end else if (busy) begin
                // One bit per clk, no idle bit between bytes
                channelOut <= {7'h00, shiftReg[3'd7 - bitCnt]};
                bitCnt     <= bitCnt + 3'd1;
            end else begin
                validOut <= 1'b0;
            end
        end
    end

    // Pin release follows the enable pin only; stream keeps running
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            streamOe_n <= 1'b1;
        end else begin
            streamOe_n <= outputEnable_n;
        end
    end

    // Serializer for the low control bits
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            serState <= RXO_SER_IDLE;
            serShift <= 8'h00;
            serBit   <= 3'd0;
            serPhase <= 16'h0000;
            serScl   <= 1'b1;
            serEn    <= 1'b0;
        end else begin
            case (serState)
                RXO_SER_IDLE: begin
                    serScl <= 1'b1;
                    serEn  <= 1'b0;
                    if (serGo) begin
                        serShift <= serData;
                        serBit   <= 3'd0;
                        serPhase <= 16'h0000;
                        serScl   <= 1'b0;
                        serEn    <= 1'b1;
                        serState <= RXO_SER_RUN;
                    end
                end
                RXO_SER_RUN: begin
                    if (serPhase == 16'(SCL_HALF - 1)) begin
                        serPhase <= 16'h0000;
                        serScl   <= !serScl || serBit == 3'd7; // Last bit ends high
                        // Data moves only after a rising clock edge
                        if (serScl) begin
                            serShift <= {serShift[6:0], 1'b0};
                            serBit   <= serBit + 3'd1;
                            if (serBit == 3'd7) begin
                                serState <= RXO_SER_END;
                            end
                        end
                    end else begin
                        serPhase <= serPhase + 16'h0001;
                    end
                end
                RXO_SER_END: begin
                    serScl <= 1'b1;
                    if (serPhase == 16'(SCL_HALF - 1)) begin
                        serEn    <= 1'b0;
                        serState <= RXO_SER_IDLE;
                    end else begin
                        serPhase <= serPhase + 16'h0001;
                    end
                end
                default: serState <= RXO_SER_IDLE;
            endcase
        end
    end

    // Control output pins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrlOut <= 4'h0;
        end else begin
            if (cfg[`RXO_CFG_B3REG]) begin
                ctrlOut[3] <= ctl[`RXO_CTL_B3_BIT];
            end else begin
                case (syncSrc)
                    RXO_SRC_VITERBI: ctrlOut[3] <= syncFlags[0];
                    RXO_SRC_DEINT:   ctrlOut[3] <= syncFlags[1];
                    RXO_SRC_DESCR:   ctrlOut[3] <= syncFlags[2];
                    default:         ctrlOut[3] <= 1'b0;
                endcase
            end
            case (lowMode)
                RXO_LOW_TUNER: begin
                    ctrlOut[2] <= ctl[`RXO_CTL_PUMP_LO];
                    ctrlOut[1] <= ctl[`RXO_CTL_GPO_LO + 1];
                    ctrlOut[0] <= ctl[`RXO_CTL_PUMP_LO + 1];
                end
                RXO_LOW_SERIAL: begin
                    ctrlOut[2] <= serEn;
                    ctrlOut[1] <= serScl;
                    ctrlOut[0] <= serShift[7];
                end
                default: ctrlOut[2:0] <= ctl[`RXO_CTL_GPO_LO +: 3];
            endcase
        end
    end

    // Two clock dividers and two sigma-delta modulators
    logic [1:0] divOut;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : gChan
            logic [DIV_W-1:0]  cnt;
            logic [DIV_W-1:0]  divisor;
            logic [DIV_W-1:0]  lastCnt;
            logic [GAIN_W:0]   acc;
            logic [GAIN_W-1:0] level;

            // Divisors below 2 would need a clk-rate toggle, so clamp
            assign divisor = (divs[8*gi +: DIV_W] < DIV_W'(2)) ? DIV_W'(2)
                                                               : divs[8*gi +: DIV_W];
            assign lastCnt = divisor - DIV_W'(1);
            assign level   = gains[8*gi +: GAIN_W];

            always_ff @(posedge clk or negedge nrst or posedge dpReset) begin
                if (!nrst || dpReset) begin
                    cnt        <= '0;
                    divOut[gi] <= 1'b0;
                end else begin
                    cnt        <= (cnt >= lastCnt) ? '0 : cnt + DIV_W'(1);
                    divOut[gi] <= cnt < (divisor >> 1);
                end
            end

            // Carry of the accumulator is the bitstream; density tracks level
            always_ff @(posedge clk or negedge nrst or posedge dpReset) begin
                if (!nrst || dpReset) begin
                    acc         <= '0;
                    gainOut[gi] <= 1'b0;
                end else begin
                    acc         <= {1'b0, acc[GAIN_W-1:0]} + {1'b0, level};
                    gainOut[gi] <= acc[GAIN_W];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            decimClkOut  <= 1'b0;
            sampleClkOut <= 1'b0;
        end else begin
            decimClkOut  <= divOut[0];
            sampleClkOut <= divOut[1];
        end
    end

endmodule

// >>> rxo_regs.svh
`ifndef RXO_REGS_SVH
`define RXO_REGS_SVH

// Register byte offsets
`define RXO_CFG_OFF      8'h00
`define RXO_CTL_OFF      8'h04
`define RXO_SER_OFF      8'h08
`define RXO_DIV_OFF      8'h0c
`define RXO_GAIN_OFF     8'h10
`define RXO_STAT_OFF     8'h14
`define RXO_FECRST_OFF   8'h18

// Config register fields
`define RXO_CFG_FMT_BIT  0
`define RXO_CFG_B3REG    1
`define RXO_CFG_SRC_LO   2
`define RXO_CFG_MODE_LO  4

// Control register fields
`define RXO_CTL_GPO_LO   0
`define RXO_CTL_B3_BIT   3
`define RXO_CTL_PUMP_LO  4

// Status register fields
`define RXO_ST_SENSE     0
`define RXO_ST_SERBUSY   1
`define RXO_ST_SYNC_LO   2
`define RXO_ST_VALID     5
`define RXO_ST_ERR       6

// Reset values
`define RXO_CFG_RST      32'h0000_0001
`define RXO_CTL_RST      32'h0000_0000
`define RXO_DIV_RST      32'h0000_0202
`define RXO_GAIN_RST     32'h0000_0000

// Half period of the serializer clock, in clk cycles
`define RXO_SCL_HALF     4

`endif

// >>> rxo_pkg.sv
package rxo_pkg;
    typedef enum logic [1:0] {
        RXO_SER_IDLE = 2'b00,
        RXO_SER_RUN  = 2'b01,
        RXO_SER_END  = 2'b11
    } rxo_ser_state_t;

    typedef enum logic [1:0] {
        RXO_LOW_GPO    = 2'b00,
        RXO_LOW_TUNER  = 2'b01,
        RXO_LOW_SERIAL = 2'b10
    } rxo_low_mode_t;

    typedef enum logic [1:0] {
        RXO_SRC_VITERBI = 2'b00,
        RXO_SRC_DEINT   = 2'b01,
        RXO_SRC_DESCR   = 2'b10
    } rxo_sync_src_t;
endpackage

// >>> rxo_demux_model.sv
`timescale 1ns/1ps
module rxo_demux_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Resolved stream pins
    input  wire logic [7:0] chan,
    input  wire logic       valid,
    input  wire logic       strobe,
    input  wire logic       serial
);
    logic [7:0] bytes [$];
    logic [7:0] shiftReg;
    int         bitCnt;

    // Serial capture every bit clock without strobe; parallel capture on strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bitCnt   <= 0;
            shiftReg <= 8'h00;
        end else if (serial && valid) begin
            shiftReg <= {shiftReg[6:0], chan[0]};
            bitCnt   <= (bitCnt == 7) ? 0 : bitCnt + 1;
            if (bitCnt == 7) begin
                bytes.push_back({shiftReg[6:0], chan[0]});
            end
        end else if (!serial && valid && strobe) begin
            bytes.push_back(chan);
        end
    end
endmodule

// >>> rxo_pins_checker.sv
`timescale 1ns/1ps
module rxo_pins_checker (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       dpReset,
    // APB handshake
    input  wire logic       psel,
    input  wire logic       penable,
    input  wire logic       pready,
    // Stream in
    input  wire logic       inValid,
    input  wire logic [7:0] inByte,
    input  wire logic       inIsData,
    input  wire logic       inFrameStart,
    input  wire logic       inFrameErr,
    input  wire logic       inReady,
    input  wire logic       outputEnable_n,
    // Stream pins
    input  wire logic [7:0] channelOut,
    input  wire logic       validOut,
    input  wire logic       byteStrobe,
    input  wire logic       frameStart,
    input  wire logic       frameError_n,
    input  wire logic       streamOe_n
);
    logic taken;
    assign taken = inValid && inReady;
    default clocking cb @(posedge clk);
    endclocking
    // Datapath reset clears the stream, so nothing is judged across it
    default disable iff (!nrst || dpReset);

    sequence serialHold;
        (validOut && !inReady) [*7] ##1 (validOut && inReady);
    endsequence
    sequence serialBits;
        channelOut[0] == $past(inByte[7]) ##7 channelOut[0] == $past(inByte[0], 8);
    endsequence

    a_valid_data_cause: assert property (
        $rose(validOut) |-> $past(taken && inIsData)) else $error("valid without data byte");
    a_strobe_per_byte: assert property (
        byteStrobe |-> validOut && $past(taken && inIsData)) else $error("stray byte strobe");
    a_parallel_byte: assert property (
        byteStrobe |-> channelOut == $past(inByte)) else $error("wrong parallel byte");
    a_start_flag_valid: assert property (
        frameStart |-> validOut && $past(taken && inFrameStart)) else $error("stray frame start");
    a_error_at_start: assert property (
        taken && inFrameStart |=> frameError_n == !$past(inFrameErr)) else $error("error flag");
    a_serial_hold: assert property (
        $fell(inReady) && validOut |-> serialHold) else $error("serial byte not 8 cycles");
    a_serial_msb: assert property (
        $fell(inReady) && validOut |-> serialBits) else $error("serial bit order");
    a_oe_follows: assert property (
        $changed(outputEnable_n) |=> streamOe_n == $past(outputEnable_n))
        else $error("output enable not followed");
    a_apb_answer: assert property (
        psel && penable && !pready |=> pready) else $error("apb answer late");
endmodule

bind rxo_pins rxo_pins_checker rxo_pins_checker_inst (
    .clk(clk), .nrst(nrst), .dpReset(dpReset), .psel(psel), .penable(penable),
    .pready(pready), .inValid(inValid), .inByte(inByte), .inIsData(inIsData),
    .inFrameStart(inFrameStart), .inFrameErr(inFrameErr), .inReady(inReady),
    .outputEnable_n(outputEnable_n), .channelOut(channelOut), .validOut(validOut),
    .byteStrobe(byteStrobe), .frameStart(frameStart), .frameError_n(frameError_n),
    .streamOe_n(streamOe_n)
);

// >>> rxo_pins_tb.sv
`timescale 1ns/1ps
`include "rxo_regs.svh"
module rxo_pins_tb;
    import rxo_pkg::*;
    logic        clk, nrst, dpReset, psel, penable, pwrite, pready, pslverr, rdErr, inReady;
    logic        inValid, inIsData, inFrameStart, inFrameErr, senseIn, outputEnable_n;
    logic        validOut, byteStrobe, frameStart, frameError_n, streamOe_n, serMode;
    logic        decimClkOut, sampleClkOut;
    logic [7:0]  paddr, inByte, channelOut;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  syncFlags;
    logic [3:0]  ctrlOut;
    logic [1:0]  gainOut;
    int          num_errors = 0, num_checks = 0, cycles = 0;

    rxo_pins #(.SCL_HALF(2)) rxo_pins_inst (
        .clk(clk), .nrst(nrst), .dpReset(dpReset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .inValid(inValid), .inByte(inByte), .inIsData(inIsData),
        .inFrameStart(inFrameStart), .inFrameErr(inFrameErr), .inReady(inReady),
        .syncFlags(syncFlags), .senseIn(senseIn), .outputEnable_n(outputEnable_n),
        .channelOut(channelOut), .validOut(validOut), .byteStrobe(byteStrobe),
        .frameStart(frameStart), .frameError_n(frameError_n), .streamOe_n(streamOe_n),
        .ctrlOut(ctrlOut), .gainOut(gainOut), .decimClkOut(decimClkOut),
        .sampleClkOut(sampleClkOut)
    );
    // Released pins read inverted, so a stale value never passes
    rxo_demux_model rxo_demux_model_inst (
        .clk(clk), .nrst(nrst), .serial(serMode), .chan(channelOut ^ {8{streamOe_n}}),
        .valid(validOut ^ streamOe_n), .strobe(byteStrobe ^ streamOe_n)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        rdErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Valid stays up between bytes; idle lowers it
    task automatic send(input logic [7:0] b, input logic d, input logic fs, input logic fe);
        inValid      <= 1'b1;
        inByte       <= b;
        inIsData     <= d;
        inFrameStart <= fs;
        inFrameErr   <= fe;
        do begin
            @(posedge clk);
        end while (inReady !== 1'b1);
    endtask
    task automatic idle();
        inValid <= 1'b0;
        wt(12);
    endtask
    task automatic got(input logic [7:0] e [$]);
        check(rxo_demux_model_inst.bytes.size(), e.size(), "byte count");
        foreach (e[i]) check(rxo_demux_model_inst.bytes[i], e[i], "captured byte");
        rxo_demux_model_inst.bytes.delete();
    endtask

    task automatic t_regs();
        apb(0, `RXO_CFG_OFF, 0);
        check(rd, `RXO_CFG_RST, "cfg reset value");
        apb(0, `RXO_DIV_OFF, 0);
        check(rd, `RXO_DIV_RST, "div reset value");
        apb(0, 8'h1c, 0);
        check(rdErr, 1, "unmapped refused");
        for (int v = 1; v >= 0; v--) begin
            senseIn <= v[0];
            wt(3);
            apb(0, `RXO_STAT_OFF, 0);
            check(rd[`RXO_ST_SENSE], v[0], "sense bit");
        end
        $display("test regs done");
    endtask
    task automatic t_parallel();
        outputEnable_n <= 1'b1;
        wt(3);
        check(streamOe_n, 1, "pins released");
        outputEnable_n <= 1'b0;
        wt(3);
        check(streamOe_n, 0, "pins driven");
        rxo_demux_model_inst.bytes.delete();
        send(8'h47, 1, 1, 1);
        send(8'h12, 1, 0, 0);
        send(8'h99, 0, 0, 0);
        send(8'h34, 1, 0, 0);
        idle();
        check(frameError_n, 0, "error held");
        send(8'h47, 1, 1, 0);
        idle();
        check(frameError_n, 1, "error released");
        got('{8'h47, 8'h12, 8'h34, 8'h47});
        $display("test parallel done");
    endtask
    task automatic t_serial();
        apb(1, `RXO_CFG_OFF, 0);
        serMode <= 1'b1;
        send(8'hb4, 1, 1, 0);
        send(8'h3c, 1, 0, 0);
        send(8'h81, 1, 0, 0);
        idle();
        got('{8'hb4, 8'h3c, 8'h81});
        apb(1, `RXO_CFG_OFF, `RXO_CFG_RST);
        serMode <= 1'b0;
        wt(2);
        $display("test serial done");
    endtask
    task automatic t_pipe();
        int lows;
        lows = 0;
        inValid  <= 1'b1;
        inIsData <= 1'b1;
        inFrameStart <= 1'b0;
        wt(4);
        fork
            apb(1, `RXO_FECRST_OFF, 1);
            repeat (7) begin
                @(posedge clk);
                lows += (validOut !== 1'b1);
            end
        join
        check(lows > 0, 1, "valid dropped");
        idle();
        rxo_demux_model_inst.bytes.delete();
        $display("test pipeline reset done");
    endtask
    task automatic t_ctrl();
        logic [7:0] sb;
        logic [3:0] prevCtl;
        int         nb;
        apb(1, `RXO_CTL_OFF, 32'h0000_000d);
        apb(1, `RXO_CFG_OFF, 32'h0000_0003);
        wt(3);
        check(ctrlOut, 4'hd, "gpo pins");
        for (int s = 0; s < 3; s++) begin
            apb(1, `RXO_CFG_OFF, {26'h0, RXO_LOW_GPO, rxo_sync_src_t'(s), 2'b01});
            syncFlags <= 3'b001 << s;
            wt(3);
            check(ctrlOut[3], 1, "in sync");
            syncFlags <= ~(3'b001 << s);
            wt(3);
            check(ctrlOut[3], 0, "out of sync");
        end
        apb(1, `RXO_CFG_OFF, {26'h0, RXO_LOW_TUNER, 4'h1});
        for (int p = 0; p < 4; p++) begin
            apb(1, `RXO_CTL_OFF, {26'h0, p[1:0], 4'h0});
            wt(3);
            check({ctrlOut[2], ctrlOut[0]}, {p[0], p[1]}, "pump gain");
        end
        apb(1, `RXO_CFG_OFF, {26'h0, RXO_LOW_SERIAL, 4'h1});
        apb(1, `RXO_SER_OFF, 32'h0000_00a6);
        nb = 0;
        sb = 8'h00;
        prevCtl = ctrlOut;
        // Bit taken from the low half before each clock rise
        repeat (120) begin
            @(posedge clk);
            if (ctrlOut[2] && !prevCtl[1] && ctrlOut[1]) begin
                sb = {sb[6:0], prevCtl[0]};
                nb++;
            end
            prevCtl = ctrlOut;
        end
        check(nb, 8, "serializer bits");
        check(sb, 8'ha6, "serializer byte");
        check(ctrlOut[2:1], 2'b01, "serializer idle");
        $display("test control done");
    endtask
    task automatic t_clocks();
        int g1, g2, n1, n2;
        {g1, g2, n1, n2} = '0;
        apb(1, `RXO_GAIN_OFF, 32'h0000_c040);
        apb(1, `RXO_DIV_OFF, 32'h0000_0305);
        wt(20);
        // 60 spans whole periods of both dividers
        repeat (256) begin
            @(posedge clk);
            g1 += gainOut[0];
            g2 += gainOut[1];
        end
        repeat (60) begin
            @(posedge clk);
            n1 += decimClkOut;
            n2 += sampleClkOut;
        end
        check(g1 inside {[63:65]}, 1, "gain 1 density");
        check(g2 inside {[191:193]}, 1, "gain 2 density");
        check(n1, 24, "decimated clock");
        check(n2, 20, "sample clock");
        $display("test clocks done");
    endtask
    task automatic t_dpreset();
        apb(1, `RXO_CFG_OFF, 32'h0000_0011);
        inValid  <= 1'b1;
        inIsData <= 1'b1;
        wt(4);
        dpReset <= 1'b1;
        wt(3);
        check({validOut, byteStrobe, frameStart}, 0, "datapath cleared");
        dpReset <= 1'b0;
        idle();
        apb(0, `RXO_CFG_OFF, 0);
        check(rd, 32'h0000_0011, "config kept");
        $display("test datapath reset done");
    endtask

    initial begin
        nrst = 1'b0;
        {psel, penable, pwrite, inValid, inIsData, inFrameStart, inFrameErr} = '0;
        {senseIn, dpReset, outputEnable_n, serMode} = '0;
        {paddr, inByte, pwdata, syncFlags} = '0;
        wt(2);
        nrst <= 1'b1;
        t_regs();
        t_parallel();
        t_serial();
        t_pipe();
        t_ctrl();
        t_clocks();
        t_dpreset();
        print_verdict();
    end
endmodule
